// ---- include/dmp_pkg.sv ----
package dmp_pkg;
   // Register word indices; the byte address is four times the index.
   localparam logic [7:0] IDX_IEN1 = 8'h05;
   localparam logic [7:0] IDX_IEN2 = 8'h06;
   localparam logic [7:0] IDX_PINCFG = 8'h0E;
   localparam logic [7:0] IDX_MODCTL = 8'h71;
   localparam logic [7:0] IDX_CTL = 8'h7C;
   localparam logic [7:0] IDX_STAT = 8'h7D;
   // Field positions of the modulation control and pin config registers.
   localparam int TRCLK_LSB = 6;
   localparam int DTMOD_LSB = 4;
   localparam int ENINV_BIT = 3;
   localparam int MODTYP_LSB = 0;
   localparam int PIN_IRQ_BIT = 3;
   // Field positions of the control register.
   localparam int CTL_TXON = 0;
   localparam int CTL_RXON = 1;
   localparam int CTL_HALF_LSB = 16;
   // Encodings of the route, source and modulation fields.
   localparam logic [1:0] CLK_NONE = 2'h0;
   localparam logic [1:0] CLK_GPIO = 2'h1;
   localparam logic [1:0] CLK_SDO = 2'h2;
   localparam logic [1:0] CLK_IRQ = 2'h3;
   localparam logic [1:0] SRC_GPIO = 2'h0;
   localparam logic [1:0] SRC_SDI = 2'h1;
   localparam logic [1:0] SRC_FIFO = 2'h2;
   localparam logic [1:0] SRC_PN9 = 2'h3;
   localparam logic [1:0] MOD_GFSK = 2'h3;
   // Values after reset, and the bus response codes.
   localparam logic [7:0] MODCTL_RST = 8'h00;
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [15:0] HALF_RST = 16'h0004;
   localparam logic [8:0] PN9_SEED = 9'h1FF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/direct_mode_data_port.sv ----
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// - Async transmit takes input level at any rate.
// - Async transmit drives no bit clock.
// - Async input sampled every internal clock cycle; here the sampler stalls while the buffer is full.
// - Async transmit only FSK or OOK; here GFSK is not blocked, status bit 0 flags it.
// - Incoming bits pass straight to modulator; here they go through the sampler and the dmp_fifo buffer.
// - Route 10, select high: clock on SDO.
// - Select low: SDO is serial read data.
// - Route 11, no interrupts: clock on IRQ.
// - Source 01 uses serial data-in pin.
// - Select decides serial data-in pin role; here it gates only the receive drive, transmit sampling ignores it.
// - Pin config bit 3 puts IRQ on SDO.
// - Test source is nine-stage PN generator.
// - Source field picks GPIO, SDI, FIFO, PN9.
// - Route 00 none, 01 clock on GPIO.
// - Sync transmit: square clock, bit per rising edge.

// ==========================================================
// Elastic buffer between the sampler and the modulator.
module dmp_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Filling side.
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side.
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rp;
      logic [AW-1:0] wp;
      logic [AW:0] cnt;
   } fst_t;
   fst_t st_ff, nxt_st;
   logic push, pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("dmp_fifo: DEPTH must be a power of two");
   end

   assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_ff.cnt != '0;
   assign out_data = st_ff.mem[st_ff.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers wrap naturally because depth is a power of two.
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// ==========================================================
// Direct-mode data port with its register slave.
module direct_mode_data_port
   import dmp_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave.
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins from the microcontroller side.
   input wire logic serial_select_n,
   input wire logic sdi_in,
   output logic sdi_out,
   output logic sdi_oe,
   output logic sdo_out,
   output logic interrupt_request_n,
   input wire logic gpio_data_in,
   output logic gpio_data_out,
   output logic gpio_data_oe,
   output logic gpio_clk_out,
   // Internal radio sources on this clock.
   input wire logic spi_read_data,
   input wire logic irq_source_n,
   input wire logic fifo_tx_bit,
   input wire logic rx_bit,
   // Transmit bits toward the modulator.
   output logic tx_bit,
   output logic tx_bit_valid,
   input wire logic tx_bit_ready
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] aw_idx;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] modctl;
      logic [7:0] ien1;
      logic [7:0] ien2;
      logic [7:0] pincfg;
      logic [31:0] ctl;
      logic [15:0] div;
      logic bclk;
      logic [8:0] pn;
      logic samp_v;
      logic samp;
      logic [1:0] sel_s;
      logic [1:0] sdi_s;
      logic [1:0] gpio_s;
      logic sdo;
      logic irq_n;
      logic sdi_o;
      logic sdi_e;
      logic gpio_o;
      logic gpio_e;
      logic gclk;
   } st_t;
   st_t st_ff, nxt_st;

   logic [1:0] trclk, dtmod;
   logic txon, rxon, sel_hi, async_tx, clk_run, tick, in_ready;
   logic no_irq, src_bit;

   // Byte-lane merge used by every writable register.
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign trclk = st_ff.modctl[TRCLK_LSB +: 2];
   assign dtmod = st_ff.modctl[DTMOD_LSB +: 2];
   assign txon = st_ff.ctl[CTL_TXON];
   assign rxon = st_ff.ctl[CTL_RXON];
   assign sel_hi = st_ff.sel_s[1];
   assign no_irq = (st_ff.ien1 == '0) && (st_ff.ien2 == '0);
   // No route means no handshake, so sampling is free-running except from the PN9 source.
   assign async_tx = txon && trclk == CLK_NONE && dtmod != SRC_PN9;
   // The divider runs for a routed clock or for the test source.
   assign clk_run = (txon || rxon) && (trclk != CLK_NONE
      || dtmod == SRC_PN9);
   assign tick = clk_run && st_ff.div == '0 && !st_ff.bclk;

   // Data source selection from the synchronised pins, the buffer bit or PN9.
   always_comb begin
      unique case (dtmod)
         SRC_GPIO: src_bit = st_ff.gpio_s[1];
         SRC_SDI: src_bit = st_ff.sdi_s[1];
         SRC_FIFO: src_bit = fifo_tx_bit;
         SRC_PN9: src_bit = st_ff.pn[0];
      endcase
   end

   // ========================================================
   // Next-state logic.
   always_comb begin
      nxt_st = st_ff;
      // Two-stage synchronisers; only stage two is read.
      nxt_st.sel_s = {st_ff.sel_s[0], serial_select_n};
      nxt_st.sdi_s = {st_ff.sdi_s[0], sdi_in};
      nxt_st.gpio_s = {st_ff.gpio_s[0], gpio_data_in};

      // Write channel: address and data taken in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.aw_got && st_ff.w_got) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         unique case (st_ff.aw_idx)
            IDX_IEN1: nxt_st.ien1 = 8'(merge({24'h0, st_ff.ien1},
               st_ff.wdata, st_ff.wstrb));
            IDX_IEN2: nxt_st.ien2 = 8'(merge({24'h0, st_ff.ien2},
               st_ff.wdata, st_ff.wstrb));
            IDX_PINCFG: nxt_st.pincfg = 8'(merge({24'h0, st_ff.pincfg},
               st_ff.wdata, st_ff.wstrb));
            IDX_MODCTL: nxt_st.modctl = 8'(merge({24'h0, st_ff.modctl},
               st_ff.wdata, st_ff.wstrb));
            IDX_CTL: nxt_st.ctl = merge(st_ff.ctl, st_ff.wdata,
               st_ff.wstrb) & 32'hFFFF_0003;
            IDX_STAT: ;
            default: nxt_st.bresp = RESP_SLVERR;
         endcase
      end else if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Read channel: answer one cycle after the address.
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         unique case (s_axi_araddr[9:2])
            IDX_IEN1: nxt_st.rdata = {24'h0, st_ff.ien1};
            IDX_IEN2: nxt_st.rdata = {24'h0, st_ff.ien2};
            IDX_PINCFG: nxt_st.rdata = {24'h0, st_ff.pincfg};
            IDX_MODCTL: nxt_st.rdata = {24'h0, st_ff.modctl};
            IDX_CTL: nxt_st.rdata = st_ff.ctl;
            // Status: bit 0 GFSK with async transmit, bit 1 select
            // high, bit 2 bit clock, bit 3 sample, bits 12:4 PN9.
            IDX_STAT: nxt_st.rdata = {19'h0, st_ff.pn, st_ff.samp,
               st_ff.bclk, sel_hi, async_tx && st_ff.modctl
               [MODTYP_LSB +: 2] == MOD_GFSK};
            default: begin
               nxt_st.rdata = 32'h0000_0000;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end

      // Bit clock divider: square wave at the programmed rate.
      if (!clk_run) begin
         nxt_st.div = st_ff.ctl[CTL_HALF_LSB +: 16];
         nxt_st.bclk = 1'b0;
      end else if (st_ff.div == '0) begin
         nxt_st.div = st_ff.ctl[CTL_HALF_LSB +: 16];
         nxt_st.bclk = !st_ff.bclk;
      end else begin
         nxt_st.div = st_ff.div - 16'h0001;
      end
      if (tick) begin
         nxt_st.pn = {st_ff.pn[4] ^ st_ff.pn[0], st_ff.pn[8:1]};
      end

      // Sampler: holds its bit while the buffer is full.
      if (st_ff.samp_v && in_ready) begin
         nxt_st.samp_v = 1'b0;
      end
      if (txon && (async_tx || tick) && (!st_ff.samp_v || in_ready))
            begin
         nxt_st.samp_v = 1'b1;
         nxt_st.samp = src_bit ^ st_ff.modctl[ENINV_BIT];
      end

      // Pin routing, registered so the pads see clean levels.
      if (!sel_hi) begin
         nxt_st.sdo = spi_read_data;
      end else if (trclk == CLK_SDO && (txon || rxon)) begin
         nxt_st.sdo = st_ff.bclk;
      end else if (st_ff.pincfg[PIN_IRQ_BIT]) begin
         nxt_st.sdo = irq_source_n;
      end else begin
         nxt_st.sdo = spi_read_data;
      end
      nxt_st.irq_n = (trclk == CLK_IRQ && no_irq && (txon || rxon))
         ? st_ff.bclk : irq_source_n;
      nxt_st.sdi_e = rxon && dtmod == SRC_SDI && sel_hi;
      nxt_st.sdi_o = rx_bit;
      nxt_st.gpio_e = rxon && dtmod == SRC_GPIO;
      nxt_st.gpio_o = rx_bit;
      nxt_st.gclk = trclk == CLK_GPIO && st_ff.bclk;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.modctl <= MODCTL_RST;
         st_ff.pincfg <= REG8_RST;
         st_ff.ctl <= {HALF_RST, 16'h0000};
         st_ff.pn <= PN9_SEED;
         st_ff.sdo <= 1'b1;
         st_ff.irq_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Buffer toward the modulator; the sampler stalls on it.
   dmp_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(st_ff.samp_v),
      .in_data(st_ff.samp),
      .in_ready(in_ready),
      .out_valid(tx_bit_valid),
      .out_data(tx_bit),
      .out_ready(tx_bit_ready)
   );

   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign sdo_out = st_ff.sdo;
   assign interrupt_request_n = st_ff.irq_n;
   assign sdi_out = st_ff.sdi_o;
   assign sdi_oe = st_ff.sdi_e;
   assign gpio_data_out = st_ff.gpio_o;
   assign gpio_data_oe = st_ff.gpio_e;
   assign gpio_clk_out = st_ff.gclk;

   // ========================================================
   // Checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_both_taken;
      st_ff.aw_got && st_ff.w_got;
   endsequence
   property p_bresp;
      s_both_taken |=> s_axi_bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("no write response");
   property p_no_clk_async;
      async_tx |=> !gpio_clk_out && st_ff.bclk == 1'b0;
   endproperty
   a_no_clk_async: assert property (p_no_clk_async)
      else $error("bit clock in async transmit");
   property p_async_sample;
      async_tx && in_ready ##1 async_tx |-> st_ff.samp_v;
   endproperty
   a_async_sample: assert property (p_async_sample)
      else $error("async input not sampled");
   property p_sample_val;
      async_tx && dtmod == SRC_SDI && in_ready |=>
         st_ff.samp == ($past(st_ff.sdi_s[1])
         ^ $past(st_ff.modctl[ENINV_BIT]));
   endproperty
   a_sample_val: assert property (p_sample_val)
      else $error("wrong sampled bit");
   property p_sdo_spi;
      !sel_hi |=> sdo_out == $past(spi_read_data);
   endproperty
   a_sdo_spi: assert property (p_sdo_spi)
      else $error("sdo not read data");
   property p_sdo_clk;
      sel_hi && trclk == CLK_SDO && txon |=> sdo_out == $past(st_ff.bclk);
   endproperty
   a_sdo_clk: assert property (p_sdo_clk)
      else $error("sdo not bit clock");
   property p_irq_clk;
      trclk == CLK_IRQ && no_irq && (txon || rxon) |=>
         interrupt_request_n == $past(st_ff.bclk);
   endproperty
   a_irq_clk: assert property (p_irq_clk)
      else $error("irq pin not bit clock");
   property p_sdi_drive;
      sdi_oe |-> $past(sel_hi) && $past(rxon);
   endproperty
   a_sdi_drive: assert property (p_sdi_drive)
      else $error("sdi driven while selected");
   property p_pn_live;
      st_ff.pn != 9'h000;
   endproperty
   a_pn_live: assert property (p_pn_live)
      else $error("pn generator stuck");
   sequence s_rise;
      clk_run && $rose(st_ff.bclk);
   endsequence
   // A route change may stop the clock in mid-period; that is legal.
   property p_half;
      s_rise ##0 (st_ff.ctl[CTL_HALF_LSB +: 16] == 16'h0004)
         |-> (st_ff.bclk || !clk_run) [*5] ##1 !st_ff.bclk;
   endproperty
   a_half: assert property (p_half)
      else $error("bit clock half period wrong");
endmodule

// ---- tb/mcu_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// Controller model that feeds bits into the radio's data pin.
module mcu_model (
   // Clocks seen by the controller.
   input wire logic link_clk,
   input wire logic bit_clk,
   // Mode chosen by the bench.
   input wire logic run_async,
   input wire logic run_sync,
   input wire logic [15:0] pattern,
   // Drive toward the shared data pin.
   output logic drive
);
   int idx = 0;
   logic last = 1'h0;
   logic rose = 1'h0;
   // Next bit of the pattern, in order.
   task automatic send();
      last = pattern[idx % 16];
      drive = last;
      idx++;
   endtask
   initial drive = 1'h1;
   // Own rate, and no clock is expected back from the radio.
   always @(posedge link_clk) begin
      if (run_async)
         send();
   end
   // A fall counts only after a rise, so a route switch on the
   // clock pin does not shift a bit in early.
   always @(posedge bit_clk) begin
      rose = run_sync;
   end
   // One new bit after each falling bit clock edge.
   always @(negedge bit_clk) begin
      if (run_sync && rose)
         send();
   end
   // The first bit is on the pin before the first clock.
   always @(posedge run_sync) begin
      idx = 0;
      rose = 1'h0;
      send();
   end
   // A released pin shows the opposite of its last level.
   always @(negedge run_sync or negedge run_async) begin
      drive = ~last;
   end
endmodule

// ---- tb/direct_mode_data_port_test.sv ----
`timescale 1ns/1ns
// ==========================================================
// Register-level test of the direct-mode data port.
module direct_mode_data_port_test
   import dmp_pkg::*;
;
   localparam logic [31:0] TX_ON = 32'h00040001;
   localparam logic [31:0] RX_ON = 32'h00040002;
   localparam logic [31:0] ALL_OFF = 32'h00040000;
   // Clock, reset and bus signals.
   logic aclk = 1'h0, aresetn = 1'h0, link_clk = 1'h0, link_run = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   // Pins and radio-side signals.
   logic serial_select_n = 1'h0, gpio_drv = 1'h0, spi_read_data = 1'h1;
   logic irq_source_n = 1'h1, fifo_tx_bit = 1'h0, rx_bit = 1'h0;
   logic tx_bit_ready = 1'h0, run_async = 1'h0, run_sync = 1'h0;
   logic sdi_out, sdi_oe, sdo_out, interrupt_request_n, gpio_data_out;
   logic gpio_data_oe, gpio_clk_out, tx_bit, tx_bit_valid, mcu_drive;
   logic sdi_pin, gpio_pin;
   logic [15:0] pattern = 16'h3A6C;
   logic q[$];
   int errors = 0, total_checks = 0, cycles = 0;
   int sdo_rises, irq_rises, len, bad, nrun, hit, same, ones;

   // Shared pins resolve from whoever drives them.
   assign sdi_pin = sdi_oe ? sdi_out : mcu_drive;
   assign gpio_pin = gpio_data_oe ? gpio_data_out : gpio_drv;
   always #5 aclk = ~aclk;
   // The link clock stands still outside frames.
   always #80 link_clk = link_run ? ~link_clk : 1'h0;

   direct_mode_data_port #(.FIFO_DEPTH(8)) i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .serial_select_n, .sdi_in(sdi_pin),
      .sdi_out, .sdi_oe, .sdo_out, .interrupt_request_n,
      .gpio_data_in(gpio_pin), .gpio_data_out, .gpio_data_oe,
      .gpio_clk_out, .spi_read_data, .irq_source_n, .fifo_tx_bit,
      .rx_bit, .tx_bit, .tx_bit_valid, .tx_bit_ready
   );
   mcu_model i_mcu (
      .link_clk, .bit_clk(sdo_out), .run_async, .run_sync, .pattern,
      .drive(mcu_drive)
   );

   // A hang counts as a mismatch and closes the run.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Ready lines stay high, so only the valids move.
   task automatic axi_write(input logic [7:0] idx, input logic [31:0] d);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            resp = s_axi_bresp;
            break;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] idx);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            break;
         end
      end
   endtask

   task automatic set_mode(input logic [7:0] m, input logic [31:0] c);
      axi_write(IDX_MODCTL, {24'h0, m});
      axi_write(IDX_CTL, c);
   endtask

   // Drains the transmit stream and records every bit taken.
   task automatic collect(input int n);
      q.delete();
      tx_bit_ready <= 1'h1;
      repeat (n) begin
         @(posedge aclk);
         if (tx_bit_valid === 1'h1)
            q.push_back(tx_bit);
      end
   endtask

   // Counts rising edges on the SDO and IRQ clock-capable pins.
   task automatic watch(input int n);
      logic s;
      logic i;
      sdo_rises = 0;
      irq_rises = 0;
      s = sdo_out;
      i = interrupt_request_n;
      repeat (n) begin
         @(posedge aclk);
         sdo_rises += (sdo_out === 1'h1 && s === 1'h0);
         irq_rises += (interrupt_request_n === 1'h1 && i === 1'h0);
         s = sdo_out;
         i = interrupt_request_n;
      end
   endtask

   // Main sequence; pin inputs need a few edges through synchronizers.
   initial begin
      wait_c(16);
      aresetn <= 1'h1;
      wait_c(2);
      check("sdo_out", sdo_out, 1'h1);
      check("irq_n", interrupt_request_n, 1'h1);
      check("tx_valid", tx_bit_valid, 1'h0);
      axi_read(IDX_MODCTL);
      check("modctl", rd, {24'h0, MODCTL_RST});
      axi_read(IDX_CTL);
      check("ctl", rd, {HALF_RST, 16'h0});
      axi_read(IDX_IEN1);
      check("ien1", rd, {24'h0, REG8_RST});
      axi_read(8'h00);
      check("unmapped rd", resp, RESP_SLVERR);
      axi_write(8'h00, 32'h1);
      check("unmapped wr", resp, RESP_SLVERR);
      axi_write(IDX_STAT, 32'hFFFFFFFF);
      check("stat wr", resp, RESP_OKAY);
      $display("test registers done");
      set_mode({CLK_SDO, SRC_SDI, 4'h0}, TX_ON);
      for (int v = 0; v < 2; v++) begin
         spi_read_data <= v[0];
         wait_c(6);
         check("sdo spi", sdo_out, v[0]);
      end
      serial_select_n <= 1'h1;
      wait_c(6);
      watch(100);
      check("sdo clock", sdo_rises, 32'h0A);
      axi_write(IDX_MODCTL, {24'h0, CLK_IRQ, 6'h0});
      // Let the pin leave its old route before counting edges.
      wait_c(2);
      watch(100);
      check("irq clock", irq_rises, 32'h0A);
      irq_source_n <= 1'h0;
      axi_write(IDX_IEN2, 32'h1);
      wait_c(4);
      check("irq pin", interrupt_request_n, 1'h0);
      axi_write(IDX_IEN2, 32'h0);
      axi_write(IDX_MODCTL, {24'h0, CLK_NONE, SRC_SDI, 4'h0});
      axi_write(IDX_PINCFG, 32'h8);
      for (int v = 0; v < 2; v++) begin
         irq_source_n <= v[0];
         wait_c(4);
         check("sdo irq", sdo_out, v[0]);
      end
      $display("test pin routes done");
      link_run <= 1'h1;
      run_async <= 1'h1;
      collect(20);
      fork
         collect(480);
         watch(480);
      join
      tx_bit_ready <= 1'h0;
      check("no clock", sdo_rises + irq_rises, 32'h0);
      len = 1;
      bad = 0;
      nrun = 0;
      for (int k = 1; k < q.size(); k++) begin
         if (q[k] === q[k-1])
            len++;
         else begin
            bad += (nrun > 0 && len % 16 != 0);
            nrun++;
            len = 1;
         end
      end
      check("run length", bad, 32'h0);
      check("run count", nrun > 8, 1'h1);
      axi_write(IDX_MODCTL, {24'h0, CLK_NONE, SRC_SDI, 2'h0, MOD_GFSK});
      axi_read(IDX_STAT);
      check("gfsk flag", rd[0], 1'h1);
      wait_c(30);
      check("fifo held", tx_bit_valid, 1'h1);
      axi_write(IDX_CTL, ALL_OFF);
      run_async <= 1'h0;
      link_run <= 1'h0;
      collect(30);
      // Eight buffered bits plus the one the stalled sampler holds.
      check("fifo depth", q.size(), 32'h9);
      check("fifo empty", tx_bit_valid, 1'h0);
      $display("test async done");
      for (int s = 0; s < 3; s += 2) begin
         for (int v = 0; v < 2; v++) begin
            gpio_drv <= v[0] ^ (s == 2);
            fifo_tx_bit <= v[0] ^ (s == 0);
            // The buffer source runs with the inversion bit set, the GPIO source without it.
            set_mode({CLK_NONE, s[1:0], s[1], 3'h0}, TX_ON);
            wait_c(4);
            collect(30);
            check("source bit", q[q.size() - 1], v[0] ^ s[1]);
            axi_write(IDX_CTL, ALL_OFF);
            collect(20);
         end
      end
      set_mode({CLK_SDO, SRC_SDI, 4'h0}, ALL_OFF);
      run_sync <= 1'h1;
      wait_c(2);
      axi_write(IDX_CTL, TX_ON);
      collect(200);
      hit = 0;
      for (int o = 0; o < 3; o++) begin
         same = 1;
         for (int k = 0; k < 12; k++)
            same &= (q[k + o] === pattern[k]);
         hit |= same;
      end
      check("sync order", hit, 1'h1);
      axi_write(IDX_CTL, RX_ON);
      run_sync <= 1'h0;
      wait_c(4);
      check("sdi oe", sdi_oe, 1'h1);
      for (int v = 0; v < 2; v++) begin
         rx_bit <= v[0];
         wait_c(3);
         check("rx data", sdi_out, v[0]);
      end
      serial_select_n <= 1'h0;
      wait_c(6);
      check("sdi oe off", sdi_oe, 1'h0);
      // Receive on the general-purpose pins with the clock beside it.
      set_mode({CLK_GPIO, SRC_GPIO, 4'h0}, RX_ON);
      wait_c(4);
      check("gpio oe", gpio_data_oe, 1'h1);
      check("gpio rx", gpio_data_out, rx_bit);
      ones = 0;
      repeat (100) begin
         @(posedge aclk);
         ones += (gpio_clk_out === 1'h1);
      end
      check("gpio clock", ones, 32'h32);
      $display("test sync and rx done");
      set_mode({CLK_NONE, SRC_PN9, 4'h0}, TX_ON);
      collect(400);
      ones = 0;
      foreach (q[k])
         ones += q[k];
      check("pn9 mix", ones > 5 && ones < q.size() - 5, 1'h1);
      $display("test pn9 done");
      end_of_test();
   end
endmodule
